/* inc/ppt_pkg.sv */
// Package with constants and types of the path position command tracker
package ppt_pkg;

  // Position width in user-unit pulses, two's complement
  localparam int POS_W = 32;
  // Path select width and monitor selector width
  localparam int SEL_W = 3;
  localparam int MON_W = 8;

  // Monitor variable codes (decimal 064, 001, 000, 002)
  localparam logic [MON_W-1:0] MON_END_TARGET = 8'h40;
  localparam logic [MON_W-1:0] MON_OUTPUT_POS = 8'h01;
  localparam logic [MON_W-1:0] MON_FEEDBACK_POS = 8'h00;
  localparam logic [MON_W-1:0] MON_FOLLOW_ERR = 8'h02;

  // Reset values
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
  localparam logic DONE_RESET = 1'b1;
  localparam logic HOMED_RESET = 1'b0;

  // Command kinds presented with a triggered path
  typedef enum logic [1:0] {
    PPT_CMD_ABS = 2'h0,
    PPT_CMD_INC = 2'h1,
    PPT_CMD_HOME = 2'h2,
    PPT_CMD_SPEED = 2'h3
  } ppt_cmd_t;

  // Tracker states, Gray coded along idle-move-stop-home-speed
  typedef enum logic [2:0] {
    PPT_IDLE = 3'h0,
    PPT_MOVE = 3'h1,
    PPT_STOP = 3'h3,
    PPT_HOME = 3'h2,
    PPT_SPEED = 3'h6
  } ppt_state_t;

endpackage

/* rtl/ppt_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ppt_pin_sync (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic pin_i, // Asynchronous pin level
  output logic level_o // Filtered level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // First stage feeds only the second; hazard of metastability stays here
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change taken only once second and third stage agree
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_o <= s3_r;
    end
  end

endmodule

/* rtl/ppt_tracker.sv */
// Path position command tracker: end target, output position, feedback, error
`timescale 1ns/100ps
// Overview of operation
// (R1) All positions are held in user-unit pulses.
// (R2) End target readable as monitor variable 064.
// (R3) Output position readable as monitor variable 001.
// (R4) Feedback position readable as monitor variable 000.
// (R5) Following error always equals output position minus feedback.
// (R6) Absolute command loads end target with data; output position holds.
// (R7) Incremental command adds data onto the end target.
// (R8) Absolute, incremental or homing command drops command-done until finished.
// (R9) During a move end target holds while output position advances.
// (R10) Move completion sets output position to end target, raises done.
// (R11) Stop keeps end target and done; output decelerates to rest.
// (R12) Stop or homing completion keeps rest position and raises done.
// (R13) Homing updates end target; completion loads index pulse coordinate.
// (R14) Homed indication drops on homing accept, rises on completion.
// (R15) Speed command updates both positions continuously, done stays low.
// (R16) Entering path mode loads both positions with feedback.
// (R17) Commander sets path select, then rising trigger launches command.
// (R18) Commander stops a command with an off-to-on stop input.
// (R19) Positions are signed 32-bit; increments wrap in two's complement.
module ppt_tracker
  import ppt_pkg::*;
(
  input wire logic ref_clk_i, // System clock, 250 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic servo_on_i, // Servo enabled, same-clock level
  input wire logic path_mode_i, // Internal path mode selected, same-clock level
  input wire logic [SEL_W-1:0] path_select_i, // Path select pins, asynchronous
  input wire logic path_trigger_input_i, // Trigger pin, asynchronous
  input wire logic stop_input_i, // Stop pin, asynchronous
  input wire logic [1:0] cmd_kind_i, // Kind of the launched path, same clock
  input wire logic [POS_W-1:0] cmd_data_i, // Target data of the launched path
  input wire logic [POS_W-1:0] profile_step_i, // Signed position step this cycle
  input wire logic profile_done_i, // Profile reached end or rest, pulse
  input wire logic home_done_i, // Homing search finished, pulse
  input wire logic [POS_W-1:0] home_index_pos_i, // Coordinate of encoder index
  input wire logic [POS_W-1:0] feedback_position_i, // Encoder counter, same clock
  input wire logic [MON_W-1:0] mon_sel_i, // Monitor variable select
  output logic [SEL_W-1:0] launched_path_o, // Path number taken at trigger
  output logic cmd_accept_o, // One-cycle pulse when a command is taken
  output logic [POS_W-1:0] end_target_o, // End target of current command
  output logic [POS_W-1:0] output_position_o, // Output position command
  output logic [POS_W-1:0] feedback_position_o, // Registered feedback position
  output logic [POS_W-1:0] following_error_o, // Output minus feedback
  output logic [POS_W-1:0] mon_data_o, // Selected monitor variable
  output logic cmd_done_o, // Command-done indication
  output logic homed_o // Homing completed indication
);

  ppt_state_t state_r;
  ppt_state_t state_nxt;
  logic [POS_W-1:0] end_target_r;
  logic [POS_W-1:0] end_target_nxt;
  logic [POS_W-1:0] out_pos_r;
  logic [POS_W-1:0] out_pos_nxt;
  logic [POS_W-1:0] fb_pos_r;
  logic [POS_W-1:0] err_r;
  logic [POS_W-1:0] mon_r;
  logic done_r;
  logic done_nxt;
  logic homed_r;
  logic homed_nxt;
  logic [SEL_W-1:0] path_r;
  logic trig_lvl;
  logic stop_lvl;
  logic trig_prev_r;
  logic stop_prev_r;
  logic active_r;
  logic [SEL_W-1:0] sel_lvl;
  logic trig_edge;
  logic stop_edge;
  logic active_now;
  logic entry;
  logic accept;
  ppt_cmd_t kind;

  // Pin inputs pass the three-stage filter
  ppt_pin_sync u_trig_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(path_trigger_input_i),
    .level_o(trig_lvl)
  );

  ppt_pin_sync u_stop_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(stop_input_i),
    .level_o(stop_lvl)
  );

  // Select bits settle before the trigger, so per-bit filtering is enough
  genvar gi;
  generate
    for (gi = 0; gi < SEL_W; gi++) begin : g_sel
      ppt_pin_sync u_sel_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(path_select_i[gi]),
        .level_o(sel_lvl[gi])
      );
    end
  endgenerate

  // Edge detection on filtered pin levels and on the servo-and-path-mode enable
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trig_prev_r <= 1'b0;
      stop_prev_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_lvl;
      stop_prev_r <= stop_lvl;
      active_r <= active_now;
    end
  end

  assign active_now = servo_on_i & path_mode_i;
  assign entry = active_now & ~active_r;
  assign trig_edge = trig_lvl & ~trig_prev_r; // R17
  assign stop_edge = stop_lvl & ~stop_prev_r; // R18
  // Entry load wins over a trigger in the same cycle
  assign accept = trig_edge & active_r & active_now;
  assign kind = ppt_cmd_t'(cmd_kind_i);
  assign cmd_accept_o = accept;

  // Next-state and position arithmetic; sums wrap in 32 bits
  always_comb begin
    state_nxt = state_r;
    end_target_nxt = end_target_r;
    out_pos_nxt = out_pos_r;
    done_nxt = done_r;
    homed_nxt = homed_r;
    if (entry) begin
      end_target_nxt = feedback_position_i; // R16
      out_pos_nxt = feedback_position_i; // R16
      state_nxt = PPT_IDLE;
    end else if (!active_now) begin
      state_nxt = PPT_IDLE;
    end else if (accept) begin
      case (kind)
        PPT_CMD_ABS: begin
          end_target_nxt = cmd_data_i; // R6
          done_nxt = 1'b0; // R8
          state_nxt = PPT_MOVE;
        end
        PPT_CMD_INC: begin
          end_target_nxt = end_target_r + cmd_data_i; // R7 R19
          done_nxt = 1'b0; // R8
          state_nxt = PPT_MOVE;
        end
        PPT_CMD_HOME: begin
          done_nxt = 1'b0; // R8
          homed_nxt = 1'b0; // R14
          state_nxt = PPT_HOME;
        end
        default: begin
          done_nxt = 1'b0; // R15
          state_nxt = PPT_SPEED;
        end
      endcase
    end else if (stop_edge && state_r != PPT_IDLE && state_r != PPT_STOP) begin
      // Stop keeps target and done; the deceleration step starts now
      out_pos_nxt = out_pos_r + profile_step_i; // R11
      state_nxt = PPT_STOP;
    end else begin
      case (state_r)
        PPT_MOVE: begin
          if (profile_done_i) begin
            out_pos_nxt = end_target_r; // R10
            done_nxt = 1'b1; // R10
            state_nxt = PPT_IDLE;
          end else begin
            out_pos_nxt = out_pos_r + profile_step_i; // R9
          end
        end
        PPT_STOP: begin
          if (profile_done_i) begin
            done_nxt = 1'b1; // R12
            state_nxt = PPT_IDLE;
          end else begin
            out_pos_nxt = out_pos_r + profile_step_i; // R11
          end
        end
        PPT_HOME: begin
          if (home_done_i) begin
            end_target_nxt = home_index_pos_i; // R13
            done_nxt = 1'b1; // R12
            homed_nxt = 1'b1; // R14
            state_nxt = PPT_IDLE;
          end else begin
            end_target_nxt = end_target_r + profile_step_i; // R13
            out_pos_nxt = out_pos_r + profile_step_i;
          end
        end
        PPT_SPEED: begin
          // Reaching set speed does not end the command
          end_target_nxt = end_target_r + profile_step_i; // R15
          out_pos_nxt = out_pos_r + profile_step_i; // R15
        end
        default: begin
        end
      endcase
    end
  end

  // State and indications
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= PPT_IDLE;
      done_r <= DONE_RESET;
      homed_r <= HOMED_RESET;
      path_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      done_r <= done_nxt;
      homed_r <= homed_nxt;
      if (trig_edge) begin
        path_r <= sel_lvl;
      end
    end
  end

  // Position registers in user-unit pulses
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      end_target_r <= POS_RESET;
      out_pos_r <= POS_RESET;
      fb_pos_r <= POS_RESET;
      err_r <= POS_RESET;
    end else begin
      end_target_r <= end_target_nxt; // R1
      out_pos_r <= out_pos_nxt; // R1
      fb_pos_r <= feedback_position_i; // R4
      // Built from next values so error matches the registers in every cycle
      err_r <= out_pos_nxt - feedback_position_i; // R5
    end
  end

  // Monitor variable readout, one cycle of latency
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mon_r <= POS_RESET;
    end else if (mon_sel_i == MON_END_TARGET) begin
      mon_r <= end_target_r; // R2
    end else if (mon_sel_i == MON_OUTPUT_POS) begin
      mon_r <= out_pos_r; // R3
    end else if (mon_sel_i == MON_FEEDBACK_POS) begin
      mon_r <= fb_pos_r; // R4
    end else if (mon_sel_i == MON_FOLLOW_ERR) begin
      mon_r <= err_r; // R5
    end else begin
      mon_r <= POS_RESET;
    end
  end

  assign end_target_o = end_target_r;
  assign output_position_o = out_pos_r;
  assign feedback_position_o = fb_pos_r;
  assign following_error_o = err_r;
  assign mon_data_o = mon_r;
  assign cmd_done_o = done_r;
  assign homed_o = homed_r;
  assign launched_path_o = path_r;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_err_match: assert property (following_error_o == output_position_o - feedback_position_o) // R5
    else $error("following error differs from output minus feedback");
  a_abs_load: assert property (accept && !entry && kind == PPT_CMD_ABS |=> // R6
    end_target_o == $past(cmd_data_i) && output_position_o == $past(output_position_o))
    else $error("absolute command load wrong");
  a_inc_accum: assert property (accept && !entry && kind == PPT_CMD_INC |=> // R7
    end_target_o == $past(end_target_o) + $past(cmd_data_i))
    else $error("incremental accumulation wrong");
  a_done_drop: assert property (accept && !entry && kind != PPT_CMD_SPEED |=> !cmd_done_o) // R8
    else $error("done not dropped on accept");
  a_move_hold: assert property (state_r == PPT_MOVE && active_now && !accept && !stop_edge && !entry |=> // R9
    end_target_o == $past(end_target_o))
    else $error("end target moved during a move");
  a_move_finish: assert property (state_r == PPT_MOVE && profile_done_i && active_now && !accept && !stop_edge
    && !entry |=> output_position_o == end_target_o && cmd_done_o && state_r == PPT_IDLE) // R10
    else $error("move completion wrong");
  a_stop_keep: assert property (stop_edge && state_r != PPT_IDLE && state_r != PPT_STOP && active_now && !accept // R11
    && !entry |=> end_target_o == $past(end_target_o) && cmd_done_o == $past(cmd_done_o) && state_r == PPT_STOP)
    else $error("stop altered target or done");
  a_stop_rest: assert property (state_r == PPT_STOP && profile_done_i && active_now && !accept && !entry |=> // R12
    cmd_done_o && output_position_o == $past(output_position_o))
    else $error("stop completion wrong");
  a_home_finish: assert property (state_r == PPT_HOME && home_done_i && active_now && !accept && !stop_edge
    && !entry |=> end_target_o == $past(home_index_pos_i) && homed_o && cmd_done_o) // R13
    else $error("homing completion wrong");
  a_home_clear: assert property (accept && !entry && kind == PPT_CMD_HOME |=> !homed_o && state_r == PPT_HOME) // R14
    else $error("homed not cleared on homing accept");
  a_speed_low: assert property (state_r == PPT_SPEED |-> !cmd_done_o) // R15
    else $error("done high under speed command");
  a_entry_load: assert property (entry |=> end_target_o == $past(feedback_position_i) // R16
    && output_position_o == $past(feedback_position_i))
    else $error("path mode entry load wrong");

  c_abs_move: cover property (accept && kind == PPT_CMD_ABS ##[1:50] state_r == PPT_MOVE && profile_done_i);
  c_stop_rest: cover property (state_r == PPT_STOP ##[1:50] state_r == PPT_IDLE);
  c_homing: cover property (accept && kind == PPT_CMD_HOME ##[1:50] homed_o);
  c_entry: cover property (entry);

endmodule

/* tb/ppt_partner.sv */
// Far-side model: path select, trigger and stop pins plus lagging encoder
`timescale 1ns/100ps
module ppt_partner
  import ppt_pkg::*;
#(
  parameter logic [POS_W-1:0] FB_INIT = 32'h0000_1234 // Power-up encoder count
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [POS_W-1:0] cmd_pos_i, // Output position command
  output logic [SEL_W-1:0] path_select_o, // Path number pins
  output logic trigger_o, // Launch pin
  output logic stop_o, // Stop pin
  output logic [POS_W-1:0] feedback_o // Encoder count in user-unit pulses
);
  logic [POS_W-1:0] lag_r;

  // Encoder trails the command by two cycles, an ideal loop with no overshoot
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lag_r <= FB_INIT;
      feedback_o <= FB_INIT;
    end else begin
      lag_r <= cmd_pos_i;
      feedback_o <= lag_r;
    end
  end

  // Pins idle low from time zero
  initial begin
    path_select_o = '0;
    trigger_o = 1'b0;
    stop_o = 1'b0;
  end

  // Path number settles through the pin filter before the trigger rises
  task automatic launch(input logic [SEL_W-1:0] path);
    @(posedge ref_clk_i);
    path_select_o <= path;
    repeat (6) @(posedge ref_clk_i);
    trigger_o <= 1'b1;
  endtask

  // Off-to-on stop request
  task automatic stop_rise();
    @(posedge ref_clk_i);
    stop_o <= 1'b1;
  endtask

  // Long low time so the filter sees a fresh edge next time
  task automatic pins_low();
    @(posedge ref_clk_i);
    trigger_o <= 1'b0;
    stop_o <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule

/* tb/ppt_tracker_test.sv */
// Self-checking bench of the path position command tracker
`timescale 1ns/100ps
module ppt_tracker_test;
  import ppt_pkg::*;
  localparam logic [POS_W-1:0] FB0 = 32'h0000_1234;
  localparam logic [POS_W-1:0] IDX = 32'hffff_ff9c;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic servo_on = 1'b1;
  logic path_mode = 1'b1;
  logic [1:0] kind = 2'h0;
  logic [POS_W-1:0] data = '0;
  logic [POS_W-1:0] step = '0;
  logic prof_done = 1'b0;
  logic home_done = 1'b0;
  logic [MON_W-1:0] mon_sel = '0;
  logic [SEL_W-1:0] sel;
  logic trig, stop_input, acc, done, homed;
  logic [SEL_W-1:0] lpath;
  logic [POS_W-1:0] fb_in, end_t, out_p, fb_o, err, mon;
  logic [POS_W-1:0] e0, o0, rec;
  int fail_count = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  ppt_partner #(.FB_INIT(FB0)) far (.ref_clk_i(clk), .rst_i(rst), .cmd_pos_i(out_p), .path_select_o(sel),
    .trigger_o(trig), .stop_o(stop_input), .feedback_o(fb_in));

  ppt_tracker dut (.ref_clk_i(clk), .rst_i(rst), .servo_on_i(servo_on), .path_mode_i(path_mode),
    .path_select_i(sel), .path_trigger_input_i(trig), .stop_input_i(stop_input), .cmd_kind_i(kind),
    .cmd_data_i(data), .profile_step_i(step), .profile_done_i(prof_done), .home_done_i(home_done),
    .home_index_pos_i(IDX), .feedback_position_i(fb_in), .mon_sel_i(mon_sel), .launched_path_o(lpath),
    .cmd_accept_o(acc), .end_target_o(end_t), .output_position_o(out_p), .feedback_position_o(fb_o),
    .following_error_o(err), .mon_data_o(mon), .cmd_done_o(done), .homed_o(homed));

  task automatic chk(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Error must track the two position outputs every cycle, moving or not
  always @(negedge clk) begin
    if (!rst) begin
      chk(err, out_p - fb_o);
    end
  end

  // Launch a path and stop just after the edge that applies the accept
  task automatic start(input logic [1:0] k, input logic [POS_W-1:0] d, input logic [SEL_W-1:0] p);
    int n;
    n = 0;
    @(posedge clk);
    kind <= k;
    data <= d;
    far.launch(p);
    @(negedge clk);
    while (acc !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n < 30), 32'h1);
    @(posedge clk);
    @(negedge clk);
    chk(32'(lpath), 32'(p));
  endtask

  // One-cycle completion pulse; rec holds the output just before it lands
  task automatic pulse(input bit home);
    @(posedge clk);
    if (home) home_done <= 1'b1;
    else prof_done <= 1'b1;
    @(negedge clk);
    rec = out_p;
    @(posedge clk);
    home_done <= 1'b0;
    prof_done <= 1'b0;
    step <= '0;
    @(negedge clk);
  endtask

  // Apply a step and check both positions after three cycles of it
  task automatic run3(input logic [POS_W-1:0] s, input logic [POS_W-1:0] de, input logic [POS_W-1:0] dout);
    @(posedge clk);
    step <= s;
    @(negedge clk);
    e0 = end_t;
    o0 = out_p;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(end_t, e0 + de);
    chk(out_p, o0 + dout);
  endtask

  task automatic mon_chk(input logic [MON_W-1:0] code, input logic [POS_W-1:0] exp);
    @(posedge clk);
    mon_sel <= code;
    @(posedge clk);
    @(negedge clk);
    chk(mon, exp);
  endtask

  task automatic t_entry();
    repeat (3) @(negedge clk);
    chk(end_t, FB0);
    chk(out_p, FB0);
    chk(32'(done), 32'h1);
    chk(32'(homed), 32'h0);
  endtask

  task automatic t_abs_inc();
    start(2'h0, 32'h7fff_fff0, 3'h1);
    chk(end_t, 32'h7fff_fff0);
    chk(out_p, FB0);
    chk(32'(done), 32'h0);
    run3(32'h5, 32'h0, 32'hf);
    pulse(1'b0);
    chk(out_p, 32'h7fff_fff0);
    chk(32'(done), 32'h1);
    far.pins_low();
    start(2'h1, 32'h20, 3'h2);
    chk(end_t, 32'h8000_0010);
    chk(32'(done), 32'h0);
    pulse(1'b0);
    chk(out_p, 32'h8000_0010);
    far.pins_low();
  endtask

  task automatic t_stop();
    start(2'h1, 32'h100, 3'h3);
    run3(32'h4, 32'h0, 32'hc);
    far.stop_rise();
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk(end_t, 32'h8000_0110);
    chk(32'(done), 32'h0);
    pulse(1'b0);
    chk(out_p, rec);
    chk(32'(done), 32'h1);
    far.pins_low();
  endtask

  task automatic t_home();
    start(2'h2, 32'h0, 3'h0);
    chk(32'(done), 32'h0);
    chk(32'(homed), 32'h0);
    run3(32'h3, 32'h9, 32'h9);
    pulse(1'b1);
    chk(end_t, IDX);
    chk(out_p, rec);
    chk(32'(done), 32'h1);
    chk(32'(homed), 32'h1);
    far.pins_low();
    mon_chk(MON_END_TARGET, IDX);
    mon_chk(MON_OUTPUT_POS, rec);
    mon_chk(MON_FEEDBACK_POS, rec);
    mon_chk(MON_FOLLOW_ERR, 32'h0);
  endtask

  // Servo off refuses triggers; servo on again reloads both positions, then homing clears homed
  task automatic t_reentry();
    @(posedge clk);
    servo_on <= 1'b0;
    far.launch(3'h6);
    repeat (6) begin
      @(negedge clk);
      chk(32'(acc), 32'h0);
    end
    far.pins_low();
    @(posedge clk);
    servo_on <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(end_t, fb_in);
    chk(out_p, fb_in);
    start(2'h2, 32'h0, 3'h5);
    chk(32'(homed), 32'h0);
    chk(32'(done), 32'h0);
    pulse(1'b1);
    chk(32'(homed), 32'h1);
    chk(end_t, IDX);
    far.pins_low();
  endtask

  task automatic t_speed();
    start(2'h3, 32'h0, 3'h4);
    run3(32'h2, 32'h6, 32'h6);
    chk(32'(done), 32'h0);
    far.stop_rise();
    repeat (10) @(posedge clk);
    pulse(1'b0);
    chk(out_p, rec);
    chk(32'(done), 32'h1);
    far.pins_low();
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_entry();
    t_abs_inc();
    t_stop();
    t_home();
    t_reentry();
    t_speed();
    end_of_test();
  end
endmodule
